//--- pkg/hbfip_pkg.sv
// Constants and carrier types of the host bus, queue and interrupt port.
package hbfip_pkg;
    localparam int NCH       = 4;
    localparam int NISR      = 5;
    localparam int HALF_LEN  = 32;
    localparam int FIFO_W    = 10;
    localparam int FIFO_D    = 4;
    localparam logic [5:0] RX_LEN_RST = 6'h20;
    localparam logic [5:0] RX_LEN_MIN = 6'h02;
    localparam logic [5:0] HALF_FULL  = 6'h20;
    // Channel area: address bit 7 low, bits 6:5 channel, bits 4:0 offset.
    localparam logic [4:0] OFF_FIFO = 5'h00;
    localparam logic [4:0] OFF_GPTR = 5'h02;
    localparam logic [4:0] OFF_RLEN = 5'h03;
    localparam logic [4:0] OFF_TCMD = 5'h04;
    localparam logic [4:0] OFF_STAT = 5'h08;
    localparam logic [4:0] OFF_MASK = 5'h10;
    localparam logic [7:0] ADR_CPTR = 8'h80;
    localparam logic [7:0] ADR_CFG  = 8'h81;
    localparam int CFG_PUSHPULL = 0;
    localparam int CFG_VISIBLE  = 1;
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam int EVT_BIT = 0;

    typedef logic [NCH-1:0][NISR-1:0][7:0] hbfip_evt_t;

    typedef struct packed {
        logic word;
        logic hiLane;
        logic none;
    } hbfip_lane_t;

    typedef struct packed {
        logic [1:0] chan;
        logic [7:0] data;
    } hbfip_txw_t;
endpackage

//--- design/hbfip_port.sv
// Host bus port with per-channel queues, transmit buffer and interrupt tree.
`timescale 1ns/1ps
`default_nettype none

module hbfip_fifo #(
    parameter int W = 10,
    parameter int D = 4
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign inReady  = (cnt_r != (AW+1)'(D));
    assign outValid = (cnt_r != '0);
    assign outData  = mem[rdPtr_r];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            cnt_r   <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= AW'((wrPtr_r + 1'b1) % D);
            end
            if (pop) begin
                rdPtr_r <= AW'((rdPtr_r + 1'b1) % D);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // hbfip_fifo

// What this block does
// - Two bus styles, 8 or 16 data lines, all registers directly addressed.
// - Each channel has 64-byte queues per direction; host sees one half.
// - High-byte-enable style: word, odd byte on D15:8, even on D7:0.
// - Low-byte-enable style: word, odd byte on D7:0, even on D15:8.
// - Static latch enable picks style by select pin; toggling with select pin low means muxed bus.
// - Byte and word queue accesses may be mixed freely.
// - Word access only when the width strap selects 16 bits.
// - Receive half length per channel programmable from 32 down to 2 bytes.
// - One interrupt pin, open-drain or push-pull by configuration bit.
// - The five event status registers clear when read.
// - Masked events neither interrupt nor show, unless visible mode.
// - Channel pointer flags channels; global pointer flags status registers.
// - Pointers clear or update after the status registers are read.
// - Interrupt goes inactive only when all pointers are clear.
// - Status and pointer updates wait while a host read is in progress.
// - Visible mode shows masked events but never in pointers or interrupt.
// - In visible mode a read clears masked and unmasked bits alike.
module hbfip_port (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              chipSelN,
    input  wire logic              readN,
    input  wire logic              writeN,
    input  wire logic              addrLatchEn,
    input  wire logic [7:0]        busAddr,
    input  wire logic              byteEnableN,
    input  wire logic              busStyleSelect,
    input  wire logic              busWidthStrap,
    input  wire logic [15:0]       hostDataIn,
    output logic [15:0]            hostDataOut,
    output logic [15:0]            hostDataOe,
    output logic                   irqPinOut,
    output logic                   irqPinOe,
    input  wire hbfip_pkg::hbfip_evt_t lineEvent,
    input  wire logic              rxLineValid,
    input  wire logic [1:0]        rxLineChan,
    input  wire logic [7:0]        rxLineData,
    output logic                   rxLineReady,
    input  wire logic [1:0]        txDrainChan,
    output logic                   txOutValid,
    input  wire logic              txOutReady,
    output hbfip_pkg::hbfip_txw_t  txOutWord
);
    import hbfip_pkg::*;

    logic [7:0]  rxMem [NCH][64];
    logic [7:0]  txMem [NCH][64];
    hbfip_evt_t  stat_r, mask_r, pend_r, clr, evtIn, taken;
    logic [7:0]  cfg_r;
    logic [NCH-1:0][NISR-1:0] gptr;
    logic [NCH-1:0] cptr, rxSwap, txSwap, txSend_r, rxHalf_r, txHalf_r;
    logic [5:0]  rxLen_r [NCH];
    logic [5:0]  rxAvail_r [NCH];
    logic [4:0]  rxPtr_r [NCH];
    logic [5:0]  rxFill_r [NCH];
    logic [5:0]  txFill_r [NCH];
    logic [5:0]  txRem_r [NCH];
    logic [4:0]  txPtr_r [NCH];
    logic        rdPrev_r, wrPrev_r, muxMode_r, alePrev_r, irqActive_r;
    logic [7:0]  latAddr_r, addr, evenB, oddB, byteV, fb0, fb1;
    logic        rdNow, wrNow, rdStart, wrStart, moto, isFifo, fifoReady;
    logic [1:0]  ch;
    hbfip_lane_t lane;
    hbfip_txw_t  drainW;
    logic        drainGo;

    // Byte lane decode for both bus styles and both widths.
    function automatic hbfip_lane_t laneOf(input logic wide, input logic evHi,
                                           input logic beN, input logic lsb);
        hbfip_lane_t l;
        l.word   = wide & ~beN & ~lsb;
        l.none   = wide & beN & lsb;
        l.hiLane = wide & (evHi ? (beN & ~lsb) : (~beN & lsb));
        return l;
    endfunction

    function automatic logic [7:0] regByte(input logic [7:0] a);
        logic [1:0] c;
        logic [4:0] o;
        c = a[6:5];
        o = a[4:0];
        regByte = 8'h00;
        if (a == ADR_CPTR) begin
            regByte = {4'h0, cptr};
        end else if (a == ADR_CFG) begin
            regByte = cfg_r;
        end else if (!a[7]) begin
            if (o == OFF_GPTR) begin
                regByte = {3'h0, gptr[c]};
            end else if (o == OFF_RLEN) begin
                regByte = {2'h0, rxLen_r[c]};
            end else if (o == OFF_TCMD) begin
                regByte = {7'h00, txSend_r[c]};
            end else if (o >= OFF_STAT && o < OFF_STAT + 5'(NISR)) begin
                regByte = stat_r[c][3'(o - OFF_STAT)];
            end else if (o >= OFF_MASK && o < OFF_MASK + 5'(NISR)) begin
                regByte = mask_r[c][3'(o - OFF_MASK)];
            end
        end
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b,
                                 input logic word);
        return word ? (a[7:1] == b[7:1]) : (a == b);
    endfunction

    assign rdNow   = ~chipSelN & ~readN;
    assign wrNow   = ~chipSelN & ~writeN;
    assign moto    = busStyleSelect & ~muxMode_r;
    assign addr    = muxMode_r ? latAddr_r : busAddr;
    assign lane    = laneOf(busWidthStrap, moto, byteEnableN, busAddr[0]);
    assign rdStart = rdNow & ~rdPrev_r & ~lane.none;
    assign wrStart = wrNow & ~wrPrev_r & ~lane.none;
    assign ch      = addr[6:5];
    assign isFifo  = ~addr[7] & (addr[4:1] == OFF_FIFO[4:1]);
    assign fb0     = rxMem[ch][{rxHalf_r[ch], rxPtr_r[ch]}];
    assign fb1     = rxMem[ch][{rxHalf_r[ch], 5'(rxPtr_r[ch] + 1'b1)}];
    // Even address byte sits low in one style and high in the other.
    assign evenB   = moto ? hostDataIn[15:8] : hostDataIn[7:0];
    assign oddB    = moto ? hostDataIn[7:0] : hostDataIn[15:8];
    assign byteV   = lane.hiLane ? hostDataIn[15:8] : hostDataIn[7:0];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdPrev_r  <= 1'b0;
            wrPrev_r  <= 1'b0;
            alePrev_r <= 1'b0;
            muxMode_r <= 1'b0;
            latAddr_r <= 8'h00;
        end else begin
            rdPrev_r  <= rdNow;
            wrPrev_r  <= wrNow;
            alePrev_r <= addrLatchEn;
            // A moving latch enable with the style select pin low means a multiplexed bus.
            if (addrLatchEn != alePrev_r && !busStyleSelect) begin
                muxMode_r <= 1'b1;
            end
            if (addrLatchEn) begin
                latAddr_r <= hostDataIn[7:0];
            end
        end
    end

    // Read data and lane enables come from flops, held for the strobe.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hostDataOut <= 16'h0000;
            hostDataOe  <= 16'h0000;
        end else if (!rdNow) begin
            hostDataOe  <= 16'h0000;
        end else if (rdStart) begin
            if (lane.word) begin
                hostDataOe <= 16'hFFFF;
                if (isFifo) begin
                    hostDataOut <= moto ? {fb0, fb1} : {fb1, fb0};
                end else if (moto) begin
                    hostDataOut <= {regByte(addr), regByte(addr | 8'h01)};
                end else begin
                    hostDataOut <= {regByte(addr | 8'h01), regByte(addr)};
                end
            end else begin
                byteOut(isFifo ? fb0 : regByte(addr));
            end
        end
    end

    task automatic byteOut(input logic [7:0] v);
        hostDataOe  <= lane.hiLane ? 16'hFF00 : 16'h00FF;
        hostDataOut <= lane.hiLane ? {v, 8'h00} : {8'h00, v};
    endtask

    always_comb begin
        evtIn = lineEvent;
        clr   = '0;
        for (int c = 0; c < NCH; c++) begin
            evtIn[c][0][EVT_BIT] = lineEvent[c][0][EVT_BIT] | rxSwap[c];
            evtIn[c][1][EVT_BIT] = lineEvent[c][1][EVT_BIT] | txSwap[c];
            for (int k = 0; k < NISR; k++) begin
                if (rdStart && hit({1'b0, 2'(c), 5'(OFF_STAT + 5'(k))},
                                   addr, lane.word)) begin
                    clr[c][k] = 8'hFF;
                end
            end
        end
    end

    // Masked events are dropped unless visible mode keeps them on show.
    assign taken = evtIn & (~mask_r |
                   {$bits(hbfip_evt_t){cfg_r[CFG_VISIBLE]}});

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stat_r <= '0;
            pend_r <= '0;
        end else if (rdNow) begin
            stat_r <= stat_r & ~clr;
            pend_r <= pend_r | taken;
        end else begin
            stat_r <= stat_r | taken | pend_r;
            pend_r <= '0;
        end
    end

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            for (int k = 0; k < NISR; k++) begin
                gptr[c][k] = |(stat_r[c][k] & ~mask_r[c][k]);
            end
            cptr[c] = |gptr[c];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irqActive_r <= 1'b0;
        end else begin
            irqActive_r <= |cptr;
        end
    end

    assign irqPinOut = cfg_r[CFG_PUSHPULL] ? ~irqActive_r : 1'b0;
    assign irqPinOe  = cfg_r[CFG_PUSHPULL] | irqActive_r;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_r  <= CFG_RST;
            mask_r <= {NCH*NISR{MASK_RST}};
        end else begin
            if (wrStart && hit(ADR_CFG, addr, lane.word)) begin
                cfg_r <= lane.word ? oddB : byteV;
            end
            for (int c = 0; c < NCH; c++) begin
                for (int k = 0; k < NISR; k++) begin
                    if (wrStart && hit({1'b0, 2'(c), 5'(OFF_MASK + 5'(k))},
                                       addr, lane.word)) begin
                        mask_r[c][k] <= !lane.word ? byteV :
                                        (k % 2 == 0) ? evenB : oddB;
                    end
                end
            end
        end
    end

    // Receive side: line fills one half while the host drains the other.
    assign rxLineReady = rxFill_r[rxLineChan] < rxLen_r[rxLineChan];

    always_ff @(posedge ref_clk) begin
        if (rxLineValid && rxLineReady) begin
            rxMem[rxLineChan][{~rxHalf_r[rxLineChan],
                               rxFill_r[rxLineChan][4:0]}] <= rxLineData;
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_chan
        logic       rdHere, wrHere, push1, push2;
        logic [5:0] popN;
        assign rdHere = rdStart & isFifo & (ch == 2'(c));
        assign wrHere = wrStart & isFifo & (ch == 2'(c));
        assign popN   = (!rdHere || rxAvail_r[c] == 6'h00) ? 6'h00 :
                        (lane.word && rxAvail_r[c] > 6'h01) ? 6'h02 : 6'h01;
        assign rxSwap[c] = (rxAvail_r[c] == 6'h00) &&
                           (rxFill_r[c] >= rxLen_r[c]);
        assign push1 = wrHere && txFill_r[c] < HALF_FULL;
        assign push2 = wrHere && lane.word && txFill_r[c] < HALF_FULL - 6'h01;
        assign txSwap[c] = txSend_r[c] && txRem_r[c] == 6'h00 &&
                           txFill_r[c] != 6'h00 && !wrHere;

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                rxLen_r[c]   <= RX_LEN_RST;
                rxHalf_r[c]  <= 1'b0;
                rxAvail_r[c] <= 6'h00;
                rxPtr_r[c]   <= 5'h00;
                rxFill_r[c]  <= 6'h00;
            end else begin
                if (wrStart &&
                    hit({1'b0, 2'(c), OFF_RLEN}, addr, lane.word)) begin
                    rxLen_r[c] <= clampLen(lane.word ? oddB : byteV);
                end
                if (rxSwap[c]) begin
                    rxHalf_r[c]  <= ~rxHalf_r[c];
                    rxAvail_r[c] <= rxFill_r[c];
                    rxPtr_r[c]   <= 5'h00;
                    rxFill_r[c]  <= 6'h00;
                end else begin
                    rxAvail_r[c] <= rxAvail_r[c] - popN;
                    rxPtr_r[c]   <= rxPtr_r[c] + popN[4:0];
                    if (rxLineValid && rxLineReady && rxLineChan == 2'(c)) begin
                        rxFill_r[c] <= rxFill_r[c] + 6'h01;
                    end
                end
            end
        end

        always_ff @(posedge ref_clk) begin
            if (push1) begin
                txMem[c][{txHalf_r[c], txFill_r[c][4:0]}] <=
                    lane.word ? evenB : byteV;
            end
            if (push2) begin
                txMem[c][{txHalf_r[c], 5'(txFill_r[c][4:0] + 1'b1)}] <= oddB;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                txHalf_r[c] <= 1'b0;
                txFill_r[c] <= 6'h00;
                txRem_r[c]  <= 6'h00;
                txPtr_r[c]  <= 5'h00;
                txSend_r[c] <= 1'b0;
            end else begin
                if (txSwap[c]) begin
                    txHalf_r[c] <= ~txHalf_r[c];
                    txRem_r[c]  <= txFill_r[c];
                    txPtr_r[c]  <= 5'h00;
                    txFill_r[c] <= 6'h00;
                end else begin
                    txFill_r[c] <= txFill_r[c] + 6'(push1) + 6'(push2);
                    if (drainGo && txDrainChan == 2'(c)) begin
                        txRem_r[c] <= txRem_r[c] - 6'h01;
                        txPtr_r[c] <= txPtr_r[c] + 5'h01;
                    end
                end
                if (wrStart && hit({1'b0, 2'(c), OFF_TCMD}, addr, lane.word)
                    && byteV[0]) begin
                    txSend_r[c] <= 1'b1;
                end else if (txSwap[c]) begin
                    txSend_r[c] <= 1'b0;
                end
            end
        end
    end

    function automatic logic [5:0] clampLen(input logic [7:0] v);
        if (v > 8'(HALF_FULL)) return HALF_FULL;
        if (v < 8'(RX_LEN_MIN)) return RX_LEN_MIN;
        return v[5:0];
    endfunction

    // The drain stalls when the buffer is full, holding the queue pointer.
    assign drainW.chan = txDrainChan;
    assign drainW.data = txMem[txDrainChan][{~txHalf_r[txDrainChan],
                                             txPtr_r[txDrainChan]}];
    assign drainGo = fifoReady && !txSwap[txDrainChan] &&
                     txRem_r[txDrainChan] != 6'h00;

    hbfip_fifo #(.W(FIFO_W), .D(FIFO_D)) u_txBuf (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .inValid (drainGo),
        .inReady (fifoReady),
        .inData  (drainW),
        .outValid(txOutValid),
        .outReady(txOutReady),
        .outData (txOutWord)
    );

    a_irq_tracks_ptr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|cptr) |=> irqActive_r) else $error("irq missed");
    a_irq_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(|cptr) |=> !irqActive_r) else $error("irq stuck");
    a_read_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(rdNow) && $past(rdNow, 2) |-> $stable(stat_r))
        else $error("status moved in read");
    a_clear_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rdStart && |(clr & stat_r) |=> (stat_r & $past(clr)) == '0)
        else $error("status not cleared");
    a_len_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rxLen_r[0] >= RX_LEN_MIN && rxLen_r[0] <= HALF_FULL)
        else $error("length out of range");
    a_narrow_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rdStart && !busWidthStrap |=> hostDataOe == 16'h00FF)
        else $error("word on narrow bus");
    a_odd_lane: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rdStart && busWidthStrap && !byteEnableN && busAddr[0] |=>
        hostDataOe == ($past(moto) ? 16'h00FF : 16'hFF00))
        else $error("odd byte lane");
    a_no_xfer: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rdNow && !rdPrev_r && lane.none |=> hostDataOe == 16'h0000)
        else $error("transfer on idle lanes");
    a_pin_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !cfg_r[CFG_PUSHPULL] |-> irqPinOe == irqActive_r && !irqPinOut)
        else $error("open drain drive");
    sequence s_rxReady;
        rxSwap[0] && rxFill_r[0] >= RX_LEN_MIN;
    endsequence
    sequence s_hostSees;
        rxAvail_r[0] == $past(rxFill_r[0]) && rxPtr_r[0] == 5'h00;
    endsequence
    a_rx_swap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_rxReady |=> s_hostSees) else $error("half not handed");
endmodule // hbfip_port

`default_nettype wire

//--- verif/hbfip_host_model.sv
// Host processor model for the parallel register bus.
`timescale 1ns/1ps
`default_nettype none
module hbfip_host_model (
    input  wire logic        ref_clk,
    input  wire logic [15:0] hostDataOut,
    input  wire logic [15:0] hostDataOe,
    output logic             chipSelN,
    output logic             readN,
    output logic             writeN,
    output logic [7:0]       busAddr,
    output logic             byteEnableN,
    output logic [15:0]      hostDataIn
);
    initial begin
        {chipSelN, readN, writeN, byteEnableN} = 4'hF;
        busAddr = 8'h00;
        hostDataIn = 16'h0000;
    end
    // A read is held over the answer edge; the strobe then rests a sample.
    task automatic access(input logic wr, input logic [7:0] a,
            input logic be, input logic [15:0] d,
            output logic [15:0] q, output logic [15:0] oe);
        {chipSelN, readN, writeN, byteEnableN} = {1'b0, wr, ~wr, be};
        busAddr = a;
        hostDataIn = d;
        @(negedge ref_clk);
        if (!wr) @(negedge ref_clk);
        q = hostDataOut;
        oe = hostDataOe;
        {chipSelN, readN, writeN} = 3'h7;
        // Released lines must not keep showing the last value.
        hostDataIn = ~d;
        @(negedge ref_clk);
    endtask
    // Multiplexed bus: the address rides the low data lines first.
    task automatic putAddr(input logic [7:0] a);
        hostDataIn = {8'h00, a};
    endtask
endmodule // hbfip_host_model
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench of the host bus, queue and interrupt port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hbfip_pkg::*;
    logic ref_clk, rst_n, addrLatchEn, busStyleSelect, busWidthStrap;
    logic chipSelN, readN, writeN, byteEnableN, rxLineValid, rxLineReady;
    logic txOutValid, txOutReady, irqPinOut, irqPinOe;
    logic [7:0] busAddr, rxLineData, m, ex[$];
    logic [1:0] rxLineChan, txDrainChan;
    logic [15:0] hostDataIn, hostDataOut, hostDataOe, q, oe;
    logic [31:0] s;
    hbfip_evt_t lineEvent;
    hbfip_txw_t txOutWord;
    int errors, compares, cyc, c, r;
    hbfip_port i_hbfip_port (.ref_clk, .rst_n, .chipSelN, .readN, .writeN,
        .addrLatchEn, .busAddr, .byteEnableN, .busStyleSelect, .busWidthStrap,
        .hostDataIn, .hostDataOut, .hostDataOe, .irqPinOut, .irqPinOe,
        .lineEvent, .rxLineValid, .rxLineChan, .rxLineData, .rxLineReady,
        .txDrainChan, .txOutValid, .txOutReady, .txOutWord);
    hbfip_host_model i_hbfip_host_model (.ref_clk, .hostDataOut, .hostDataOe,
        .chipSelN, .readN, .writeN, .busAddr, .byteEnableN, .hostDataIn);
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    // Where an even/odd register pair lands on the data lines.
    function automatic logic [15:0] lane(input logic sty, input logic be,
            input logic lsb, input logic [7:0] ev, input logic [7:0] od);
        if (!be && !lsb) return sty ? {ev, od} : {od, ev};
        if (lsb) return sty ? {8'h00, od} : {od, 8'h00};
        return sty ? {ev, 8'h00} : {8'h00, ev};
    endfunction
    function automatic logic [7:0] ga(input int ch, input int off);
        return {1'b0, ch[1:0], off[4:0]};
    endfunction
    task automatic chk(input string w, input logic [15:0] v,
            input logic [15:0] e);
        compares++;
        if (v !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", w, e, v);
        end
    endtask
    task automatic conclude();
        if (errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic be,
            input logic [7:0] ev, input logic [7:0] od);
        i_hbfip_host_model.access(1'b0, a, be, 16'h0000, q, oe);
        chk("data", q & oe, lane(busStyleSelect, be, a[0], ev, od));
        chk("lanes", oe, lane(busStyleSelect, be, a[0], 8'hFF, 8'hFF));
    endtask
    task automatic wr(input logic [7:0] a, input logic be,
            input logic [7:0] ev, input logic [7:0] od);
        i_hbfip_host_model.access(1'b1, a, be,
            lane(busStyleSelect, be, a[0], ev, od), q, oe);
    endtask
    task automatic rb(input logic [7:0] a, input logic [7:0] v);
        rd(a, ~a[0], v, v);
    endtask
    task automatic wb(input logic [7:0] a, input logic [7:0] v);
        wr(a, ~a[0], v, v);
    endtask
    task automatic pulse(input int ch, input int rg, input logic [7:0] v);
        lineEvent[ch][rg] = v;
        @(negedge ref_clk);
        lineEvent = '0;
        repeat (3) @(negedge ref_clk);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // The whole run needs a few hundred cycles; a hang stops well after.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        {rst_n, addrLatchEn, busStyleSelect, rxLineValid, txOutReady} = 5'h00;
        {busWidthStrap, rxLineChan, rxLineData, txDrainChan} = 13'h1000;
        lineEvent = '0;
        s = 32'hEB4A;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        chk("oe", hostDataOe, 16'h0000);
        chk("irq", 16'({irqPinOe, rxLineReady, txOutValid}), 16'h0002);
        rd(8'h02, 1'b0, 8'h00, {2'b00, RX_LEN_RST});
        for (int k = 0; k < 2; k++) begin
            busStyleSelect = k[0];
            wr(8'h30, 1'b0, 8'hA5, 8'h3C);
            rd(8'h30, 1'b0, 8'hA5, 8'h3C);
            rd(8'h31, 1'b0, 8'hA5, 8'h3C);
            rd(8'h30, 1'b1, 8'hA5, 8'h3C);
        end
        busStyleSelect = 1'b0;
        busWidthStrap = 1'b0;
        i_hbfip_host_model.access(1'b0, 8'h31, 1'b0, 16'h0000, q, oe);
        chk("narrow", q & oe, 16'h003C);
        busWidthStrap = 1'b1;
        i_hbfip_host_model.access(1'b0, 8'h81, 1'b1, 16'h0000, q, oe);
        chk("none", oe, 16'h0000);
        wr(8'h30, 1'b0, MASK_RST, MASK_RST);
        wb(8'h03, 8'h01);
        rd(8'h02, 1'b0, 8'h00, {2'b00, RX_LEN_MIN});
        for (int k = 0; k < 2; k++) begin
            s = xs(s);
            ex.push_back(s[7:0]);
            {rxLineValid, rxLineData} = {1'b1, s[7:0]};
            @(negedge ref_clk);
        end
        rxLineValid = 1'b0;
        repeat (4) @(negedge ref_clk);
        rd(8'h00, 1'b0, ex[0], ex[1]);
        rb(ga(0, OFF_STAT), 8'h01 << EVT_BIT);
        for (int i = 0; i < 4; i++) begin
            s = xs(s);
            c = s[1:0];
            r = s[4:2] % NISR;
            m = 8'h01 << s[7:5];
            pulse(c, r, m);
            rb(ADR_CPTR, 8'h01 << c);
            rb(ga(c, OFF_GPTR), 8'h01 << r);
            chk("irq held", 16'(irqPinOe), 16'h0001);
            rb(ga(c, OFF_STAT + r), m);
            rb(ga(c, OFF_STAT + r), 8'h00);
            chk("irq off", 16'(irqPinOe), 16'h0000);
            wb(ga(c, OFF_MASK + r), m);
            pulse(c, r, m);
            chk("masked", 16'(irqPinOe), 16'h0000);
            rb(ga(c, OFF_STAT + r), 8'h00);
            wb(ADR_CFG, 8'h01 << CFG_VISIBLE);
            pulse(c, r, m);
            chk("visible", 16'(irqPinOe), 16'h0000);
            rb(ADR_CPTR, 8'h00);
            rb(ga(c, OFF_STAT + r), m);
            rb(ga(c, OFF_STAT + r), 8'h00);
            wb(ADR_CFG, CFG_RST);
            wb(ga(c, OFF_MASK + r), MASK_RST);
            fork
                rb(ga(c, OFF_STAT + r), 8'h00);
                begin
                    @(negedge ref_clk);
                    pulse(c, r, m);
                end
            join
            rb(ga(c, OFF_STAT + r), m);
        end
        wb(ADR_CFG, 8'h01 << CFG_PUSHPULL);
        chk("pp idle", 16'({irqPinOe, irqPinOut}), 16'h0003);
        pulse(1, 0, 8'h80);
        chk("pp low", 16'({irqPinOe, irqPinOut}), 16'h0002);
        rb(ga(1, OFF_STAT), 8'h80);
        wb(ADR_CFG, CFG_RST);
        s = xs(s);
        wr(8'h00, 1'b0, s[7:0], s[15:8]);
        wr(8'h00, 1'b1, s[23:16], s[23:16]);
        wr(8'h00, 1'b0, s[31:24], s[7:0]);
        ex = '{s[7:0], s[15:8], s[23:16], s[31:24], s[7:0]};
        wb(ga(0, OFF_TCMD), 8'h01);
        repeat (20) @(negedge ref_clk);
        chk("tx stall", 16'(txOutValid), 16'h0001);
        txOutReady = 1'b1;
        foreach (ex[k]) begin
            for (int t = 0; t < 50 && txOutValid !== 1'b1; t++)
                @(negedge ref_clk);
            chk("tx word", 16'(txOutWord), {8'h00, ex[k]});
            @(negedge ref_clk);
        end
        chk("tx empty", 16'(txOutValid), 16'h0000);
        // One latch pulse makes the bus multiplexed; the strobe-time
        // address points at a queue, so only the latched one hits config.
        i_hbfip_host_model.putAddr(ADR_CFG);
        addrLatchEn = 1'b1;
        @(negedge ref_clk);
        addrLatchEn = 1'b0;
        wb(8'h01, 8'h01 << CFG_VISIBLE);
        rb(8'h01, 8'h01 << CFG_VISIBLE);
        // A second reset must drop the multiplexed mode and the irq.
        rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        chk("rst", {hostDataOe[14:0], irqPinOe}, 16'h0000);
        rd(8'h02, 1'b0, 8'h00, {2'b00, RX_LEN_RST});
        conclude();
    end
endmodule // tb_top
`default_nettype wire
